// ### alpha_decoder_pkg.sv
// Shared constants for the paging alphanumeric and secure message decoder
package alpha_decoder_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] INFO_OFFSET = 8'h0C;
  localparam logic [7:0] TEXT_OFFSET = 8'h10;
  // Control fields and reset value
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // Status and mask fields
  localparam int STATUS_WIDTH = 6;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_SIG_BIT = 1;
  localparam int ST_CHECK_BIT = 2;
  localparam int ST_NUL_BIT = 3;
  localparam int ST_SEQ_BIT = 4;
  localparam int ST_RSVD_BIT = 5;
  localparam logic [5:0] MASK_RESET = 6'h00;
  // Information word field positions
  localparam int CHECK_LSB = 0;
  localparam int CONT_BIT = 10;
  localparam int FRAG_LSB = 11;
  localparam int MSGNUM_LSB = 13;
  localparam int SPLIT_LSB = 19;
  localparam int CHAR_BITS = 7;
  localparam int WORD_BITS = 21;
  // Codes
  localparam logic [6:0] CHAR_NUL = 7'h00;
  localparam logic [6:0] CHAR_ETX = 7'h03;
  localparam logic [1:0] FRAG_START = 2'h3;
  localparam logic [1:0] SPLIT_NONE = 2'h0;
  localparam logic [1:0] SPLIT_RESERVED = 2'h1;
  localparam logic [1:0] SPLIT_DEFAULT = 2'h2;
  localparam logic [1:0] SPLIT_ALT = 2'h3;
  // Text buffer depth
  localparam int TEXT_ADDR_BITS = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHAR = 2'b01,
    ST_CHECK = 2'b10
  } dec_state_type;

  // Sum of the three check groups of one information word
  function automatic logic [9:0] group_sum(input logic [20:0] w);
    group_sum = {2'h0, w[7:0]} + {2'h0, w[15:8]} + {5'h00, w[20:16]};
  endfunction : group_sum
endpackage : alpha_decoder_pkg

// ### frag_sum.sv
// Running ten-bit fragment check accumulator
`timescale 1ns/1ps
module frag_sum
  import alpha_decoder_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Word stream
  input wire logic clear,
  input wire logic add,
  input wire logic [20:0] word,
  // Result
  output logic [9:0] sum_q
);
  logic [9:0] sum_d;
  logic [9:0] base;

  // Clear restarts from zero so the header word can be added the same cycle
  always_comb begin
    base = clear ? 10'h000 : sum_q;
    sum_d = base;
    if (add) begin
      sum_d = base + group_sum(word);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sum_q <= 10'h000;
    end else begin
      sum_q <= sum_d;
    end
  end
endmodule : frag_sum

// ### text_mem.sv
// Reassembled message text store with registered read port
`timescale 1ns/1ps
module text_mem
  import alpha_decoder_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [6:0] wdata,
  // Read port
  input wire logic [7:0] raddr,
  output logic [6:0] rdata_q
);
  logic [6:0] mem [0:(1 << TEXT_ADDR_BITS) - 1];

  // Storage has no reset; the pointers in front of it define what is valid
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule : text_mem

// ### alpha_decoder.sv
// Alphanumeric and secure paging message decoder with APB registers
// Notes on behaviour
// - Signature is inverted seven-bit sum of characters after the signature
// - Split-rules pair is only looked for in later fragments
// - Text starts second char of word two, first char in later fragments
// - Null only as fragment-end fill, dropped; elsewhere it is an error
// - No end-of-text needed when message fills the last position
// - First fragment always uses the default character mode
// - Pair 00 no support, 01 reserved, 10 default, 11 alternate mode
// - Pair 00 allows split characters; else fragment starts on boundary
// - Header word: check, continued, fragment number, message number, split-rules pair
// - Secure text words hold three chars, low bits first
// - Fragments arriving later are reassembled in order
// - Fragment check is inverted ten-bit sum of three word groups
// - Fragment number starts at 3, then counts 0,1,2 modulo 3
// - Continued flag set means more fragments follow; clear ends it
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module alpha_decoder
  import alpha_decoder_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Corrected information words
  input wire logic word_valid,
  input wire logic [20:0] word_info,
  input wire logic word_secure,
  input wire logic frag_end,
  output logic word_ready,
  // Interrupt
  output logic irq
);
  dec_state_type state_q, state_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [5:0] status_q, status_d, mask_q, mask_d, ev_set;
  logic [20:0] word_q, word_d;
  logic secure_q, secure_d, last_q, last_d;
  logic [1:0] ci_q, ci_d;
  logic [6:0] widx_q, widx_d;
  logic [9:0] kchk_q, kchk_d;
  logic cont_q, cont_d, first_q, first_d, in_msg_q, in_msg_d;
  logic [1:0] nxt_frag_q, nxt_frag_d;
  logic [5:0] msgnum_q, msgnum_d;
  logic [6:0] sig_q, sig_d, sig_sum_q, sig_sum_d;
  logic alt_q, alt_d, split_q, split_d;
  logic nul_seen_q, nul_seen_d, etx_seen_q, etx_seen_d;
  logic [8:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [9:0] ksum;
  logic [6:0] ch, mem_rdata;
  logic accept, hdr, cap_sig, wr_en, apb_wr, apb_rd, mapped, empty, full;
  logic [1:0] frag_f, uv;

  assign accept = (state_q == ST_IDLE) && word_valid &&
                  ctrl_q[CTRL_ENABLE_BIT];
  assign word_ready = (state_q == ST_IDLE) && ctrl_q[CTRL_ENABLE_BIT];
  assign hdr = accept && (widx_q == 7'h00);
  assign frag_f = word_info[FRAG_LSB +: 2];
  assign uv = word_info[SPLIT_LSB +: 2];
  assign ch = word_q[ci_q * CHAR_BITS +: CHAR_BITS];
  // Signature sits in the first field of word two of an initial alpha frag
  assign cap_sig = (state_q == ST_CHAR) && !secure_q && first_q &&
                   (widx_q == 7'h01) && (ci_q == 2'h0);
  assign empty = (wr_ptr_q == rd_ptr_q);
  assign full = (wr_ptr_q[7:0] == rd_ptr_q[7:0]) && !empty;

  // Check field is zeroed so the sum covers control and text bits only
  frag_sum u_sum (
    .pclk(pclk),
    .presetn(presetn),
    .clear(hdr),
    .add(accept),
    .word(hdr ? {word_info[20:10], 10'h000} : word_info),
    .sum_q(ksum)
  );

  text_mem u_text (
    .pclk(pclk),
    .we(wr_en),
    .waddr(wr_ptr_q[7:0]),
    .wdata(ch),
    .raddr(rd_ptr_d[7:0]),
    .rdata_q(mem_rdata)
  );

  // Word intake, character walk and per-fragment checks
  always_comb begin
    state_d = state_q;
    word_d = word_q;
    secure_d = secure_q;
    last_d = last_q;
    ci_d = ci_q;
    widx_d = widx_q;
    kchk_d = kchk_q;
    cont_d = cont_q;
    first_d = first_q;
    in_msg_d = in_msg_q;
    nxt_frag_d = nxt_frag_q;
    msgnum_d = msgnum_q;
    sig_d = sig_q;
    sig_sum_d = sig_sum_q;
    alt_d = alt_q;
    split_d = split_q;
    nul_seen_d = nul_seen_q;
    etx_seen_d = etx_seen_q;
    ev_set = 6'h00;
    wr_en = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          word_d = word_info;
          secure_d = word_secure;
          last_d = frag_end;
          ci_d = 2'h0;
          state_d = ST_CHAR;
          if (hdr) begin
            // Split pair bits are looked at only in later alpha fragments
            kchk_d = word_info[CHECK_LSB +: 10];
            cont_d = word_info[CONT_BIT];
            nul_seen_d = 1'b0;
            etx_seen_d = 1'b0;
            state_d = frag_end ? ST_CHECK : ST_IDLE;
            widx_d = 7'h01;
            if (frag_f == FRAG_START) begin
              // Initial fragment: no split-rules pair, default mode
              first_d = 1'b1;
              in_msg_d = 1'b1;
              nxt_frag_d = 2'h0;
              msgnum_d = word_info[MSGNUM_LSB +: 6];
              sig_sum_d = 7'h00;
              alt_d = 1'b0;
              split_d = 1'b0;
            end else begin
              first_d = 1'b0;
              // Out-of-order or foreign fragment breaks reassembly
              if (!in_msg_q || frag_f != nxt_frag_q ||
                  word_info[MSGNUM_LSB +: 6] != msgnum_q) begin
                ev_set[ST_SEQ_BIT] = 1'b1;
              end
              nxt_frag_d = (nxt_frag_q == 2'h2) ? 2'h0 : nxt_frag_q + 2'h1;
              if (!word_secure) begin
                // Pair decode for later alpha fragments
                case (uv)
                  SPLIT_NONE: split_d = 1'b1;
                  SPLIT_DEFAULT: begin
                    split_d = 1'b0;
                    alt_d = 1'b0;
                  end
                  SPLIT_ALT: begin
                    split_d = 1'b0;
                    alt_d = 1'b1;
                  end
                  default: ev_set[ST_RSVD_BIT] = 1'b1;
                endcase
              end
            end
          end
        end
      end
      ST_CHAR: begin
        if (cap_sig) begin
          sig_d = ch;
        end else begin
          if (!secure_q) begin
            sig_sum_d = sig_sum_q + ch;
          end
          if (ch == CHAR_NUL) begin
            nul_seen_d = 1'b1;
          end else begin
            // Text after a null proves the null was not fill
            if (nul_seen_q) begin
              ev_set[ST_NUL_BIT] = 1'b1;
            end
            if (ch == CHAR_ETX) begin
              etx_seen_d = 1'b1;
            end else if (!etx_seen_q && !full) begin
              wr_en = 1'b1;
            end
          end
        end
        ci_d = ci_q + 2'h1;
        if (ci_q == 2'h2) begin
          widx_d = widx_q + 7'h01;
          state_d = last_q ? ST_CHECK : ST_IDLE;
        end
      end
      ST_CHECK: begin
        widx_d = 7'h00;
        if (~ksum != kchk_q) begin
          ev_set[ST_CHECK_BIT] = 1'b1;
        end
        if (!cont_q) begin
          // Final fragment; no end-of-text is demanded
          ev_set[ST_DONE_BIT] = 1'b1;
          in_msg_d = 1'b0;
          if (!secure_q && (~sig_sum_q != sig_q)) begin
            ev_set[ST_SIG_BIT] = 1'b1;
          end
        end
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      word_q <= 21'h000000;
      secure_q <= 1'b0;
      last_q <= 1'b0;
      ci_q <= 2'h0;
      widx_q <= 7'h00;
      kchk_q <= 10'h000;
      cont_q <= 1'b0;
      first_q <= 1'b0;
      in_msg_q <= 1'b0;
      nxt_frag_q <= 2'h0;
      msgnum_q <= 6'h00;
      sig_q <= 7'h00;
      sig_sum_q <= 7'h00;
      alt_q <= 1'b0;
      split_q <= 1'b0;
      nul_seen_q <= 1'b0;
      etx_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      secure_q <= secure_d;
      last_q <= last_d;
      ci_q <= ci_d;
      widx_q <= widx_d;
      kchk_q <= kchk_d;
      cont_q <= cont_d;
      first_q <= first_d;
      in_msg_q <= in_msg_d;
      nxt_frag_q <= nxt_frag_d;
      msgnum_q <= msgnum_d;
      sig_q <= sig_d;
      sig_sum_q <= sig_sum_d;
      alt_q <= alt_d;
      split_q <= split_d;
      nul_seen_q <= nul_seen_d;
      etx_seen_q <= etx_seen_d;
    end
  end

  // APB decode; zero wait states because the text read is set up early
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign mapped = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET) ||
                  (paddr == MASK_OFFSET) || (paddr == INFO_OFFSET) ||
                  (paddr == TEXT_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign irq = |(status_q & mask_q);

  // Registers, sticky status with read clear, text pointers
  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    wr_ptr_d = wr_en ? wr_ptr_q + 9'h001 : wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    status_d = status_q;
    if (apb_rd && paddr == STATUS_OFFSET) begin
      status_d = 6'h00;
    end
    // An event in the clearing cycle still lands
    status_d = status_d | ev_set;
    if (apb_wr && paddr == CTRL_OFFSET) begin
      ctrl_d = pwdata[1:0];
    end
    if (apb_wr && paddr == MASK_OFFSET) begin
      mask_d = pwdata[5:0];
    end
    if (apb_rd && paddr == TEXT_OFFSET && !empty) begin
      rd_ptr_d = rd_ptr_q + 9'h001;
    end
    // Flush drops all buffered text; it self-clears
    if (ctrl_q[CTRL_FLUSH_BIT]) begin
      ctrl_d[CTRL_FLUSH_BIT] = 1'b0;
      rd_ptr_d = wr_ptr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
      status_q <= 6'h00;
      wr_ptr_q <= 9'h000;
      rd_ptr_q <= 9'h000;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      status_q <= status_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Read mux
  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      case (paddr)
        CTRL_OFFSET: prdata = {30'h0, ctrl_q};
        STATUS_OFFSET: prdata = {26'h0, status_q};
        MASK_OFFSET: prdata = {26'h0, mask_q};
        INFO_OFFSET: prdata = {15'h0, wr_ptr_q - rd_ptr_q, split_q, alt_q,
                               msgnum_q};
        TEXT_OFFSET: prdata = empty ? 32'h0 : {25'h0, mem_rdata};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // Checks on the decode path
  a_sig_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_CHECK && !cont_q && !secure_q && ~sig_sum_q != sig_q)
    |=> status_q[ST_SIG_BIT]) else $error("signature mismatch not flagged");
  a_first_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (hdr && frag_f == FRAG_START) |=> (!alt_q && !split_q))
    else $error("initial fragment not in default mode");
  a_sig_place: assert property (@(posedge pclk) disable iff (!presetn)
    cap_sig |-> !wr_en ##1 (sig_q == $past(ch) &&
    sig_sum_q == $past(sig_sum_q)))
    else $error("signature field taken wrongly");
  a_nul_error: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_CHAR && !cap_sig && nul_seen_q && ch != CHAR_NUL)
    |=> status_q[ST_NUL_BIT]) else $error("embedded null not flagged");
  a_nul_drop: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en |-> (ch != CHAR_NUL && ch != CHAR_ETX))
    else $error("fill character stored as text");
  a_alt_decode: assert property (@(posedge pclk)
    disable iff (!presetn)
    (hdr && !word_secure && frag_f != FRAG_START && uv == SPLIT_ALT)
    |=> (alt_q && !split_q)) else $error("alternate mode not selected");
  a_split_allow: assert property (@(posedge pclk)
    disable iff (!presetn)
    (hdr && !word_secure && frag_f != FRAG_START && uv == SPLIT_NONE)
    |=> split_q) else $error("split not allowed on zero pair");
  a_hdr_fields: assert property (@(posedge pclk)
    disable iff (!presetn)
    (hdr && frag_f == FRAG_START) |=> (msgnum_q == $past(word_info[18:13])
    && kchk_q == $past(word_info[9:0]))) else $error("header fields lost");
  a_char_walk: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && !frag_end && widx_q != 7'h00) |=> (state_q == ST_CHAR)
    [*3] ##1 (state_q == ST_IDLE)) else $error("three-char walk broken");
  a_check_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_q == ST_CHECK && ~ksum != kchk_q) |=> status_q[ST_CHECK_BIT])
    else $error("fragment check mismatch not flagged");
  a_seq_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (hdr && frag_f != FRAG_START && frag_f != nxt_frag_q)
    |=> status_q[ST_SEQ_BIT]) else $error("fragment order error not flagged");
  a_cont_open: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == ST_CHECK && cont_q) |=> in_msg_q)
    else $error("continued message closed early");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_set[ST_SIG_BIT] && mask_q[ST_SIG_BIT] && !(psel && penable))
    |=> ##[0:1] irq) else $error("masked-in error did not interrupt");
  c_msg_done: cover property (@(posedge pclk) disable iff (!presetn)
    ev_set[ST_DONE_BIT] && !ev_set[ST_SIG_BIT]);
  c_multi_frag: cover property (@(posedge pclk) disable iff (!presetn)
    hdr && frag_f == 2'h1 && !ev_set[ST_SEQ_BIT]);
  c_text_read: cover property (@(posedge pclk) disable iff (!presetn)
    apb_rd && paddr == TEXT_OFFSET && !empty);
endmodule : alpha_decoder

// ### page_encoder_model.sv
// Behavioural model of the paging terminal encoder feeding decoded words
`timescale 1ns/1ps
module page_encoder_model (
  // Clock
  input wire logic pclk,
  // Word handshake towards the decoder
  input wire logic word_ready,
  output logic word_valid,
  output logic [20:0] word_info,
  output logic word_secure,
  output logic frag_end
);
  // Idle cycles before each word, plus one; a large value models a later frame
  int gap = 0;

  // Quiet bus at time zero
  initial begin
    word_valid = 1'b0;
    word_info = 21'h000000;
    word_secure = 1'b0;
    frag_end = 1'b0;
  end

  // Offer one word and hold it until the decoder takes it
  task automatic put(input logic [20:0] w, input logic s, input logic l);
    int n;
    repeat (gap + 1) @(posedge pclk);
    word_valid <= 1'b1;
    word_info <= w;
    word_secure <= s;
    frag_end <= l;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (word_ready !== 1'b1 && n < 50);
    // Released word_info and frag_end show junk so a stale word is never mistaken for data
    word_valid <= 1'b0;
    word_info <= ~w;
    frag_end <= ~l;
  endtask : put
endmodule : page_encoder_model

// ### alpha_decoder_tb_top.sv
// Self-checking bench for the paging alphanumeric message decoder
`timescale 1ns/1ps
module alpha_decoder_tb_top;
  import alpha_decoder_pkg::*;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } row_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic word_valid, word_secure, frag_end, word_ready;
  logic [20:0] word_info;
  logic [6:0] fc[$], all[$], sig;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  row_type rows[10];

  alpha_decoder i_alpha_decoder (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .word_valid, .word_info,
    .word_secure, .frag_end, .word_ready, .irq);
  page_encoder_model i_page_encoder_model (.pclk, .word_ready, .word_valid,
    .word_info, .word_secure, .frag_end);

  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [9:0] gs(input logic [20:0] x);
    return 10'(x[7:0]) + 10'(x[15:8]) + 10'(x[20:16]);
  endfunction : gs

  function automatic logic [6:0] sigf(input logic [6:0] q[$]);
    logic [6:0] s;
    s = 7'h00;
    foreach (q[i]) s += q[i];
    return ~s;
  endfunction : sigf

  // Build one fragment from fc, with header check, and hand it to the encoder
  task automatic frag(input logic s, input logic [1:0] f, input logic c,
                      input logic [5:0] n, input logic [1:0] p, input logic kb);
    logic [6:0] q[$];
    logic [20:0] w[$];
    logic [20:0] h;
    logic [9:0] k;
    q = fc;
    if (f == FRAG_START) apb(1'b1, CTRL_OFFSET, 32'h3);
    if (!s && f == FRAG_START) q.push_front(sig);
    h = {p, n, f, c, 10'h000};
    k = gs(h);
    for (int i = 0; i < q.size(); i += 3) begin
      w.push_back({q[i+2], q[i+1], q[i]});
      k += gs(w[$]);
    end
    h[9:0] = ~k ^ {9'h000, kb};
    i_page_encoder_model.put(h, s, 1'b0);
    foreach (w[i]) i_page_encoder_model.put(w[i], s, i == w.size() - 1);
  endtask : frag

  // Wait past the check cycle until the decoder takes words again
  task automatic idle();
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (word_ready !== 1'b1 && n < 30) begin
      @(posedge pclk);
      n++;
    end
  endtask : idle

  task automatic stat(input logic [5:0] m, input logic [5:0] x);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rd & {26'h0, m}, {26'h0, x});
  endtask : stat

  // Pop m expected characters of all, then expect an empty store
  task automatic txt(input int m);
    for (int i = 0; i <= m; i++) begin
      apb(1'b0, TEXT_OFFSET, 32'h0);
      chk(rd, (i < m) ? {25'h0, all[i]} : 32'h0);
    end
  endtask : txt

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Register table rows: reset values, unmapped place, mask access
    rows = '{'{0, CTRL_OFFSET, 0, 32'h1, 0}, '{0, STATUS_OFFSET, 0, 0, 0},
      '{0, MASK_OFFSET, 0, 0, 0}, '{0, INFO_OFFSET, 0, 0, 0},
      '{0, TEXT_OFFSET, 0, 0, 0}, '{0, 8'h14, 0, 0, 1},
      '{1, 8'h14, 32'hFF, 0, 1}, '{1, MASK_OFFSET, 32'h3F, 0, 0},
      '{0, MASK_OFFSET, 0, 32'h3F, 0}, '{1, MASK_OFFSET, 32'h1, 0, 0}};
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].r);
      chk(er, rows[i].e);
    end
    // Single fragment, fill at the end, stray pair in the initial header
    all = '{7'h48, 7'h69, CHAR_ETX, CHAR_NUL, CHAR_NUL};
    sig = sigf(all);
    fc = all;
    frag(1'b0, FRAG_START, 1'b0, 6'h05, SPLIT_RESERVED, 1'b0);
    idle();
    chk(irq, 32'h1);
    stat(6'h3F, 6'h01);
    // The read clear lands at the access edge, so look one edge later
    @(posedge pclk);
    chk(irq, 32'h0);
    apb(1'b0, INFO_OFFSET, 32'h0);
    chk(rd & 32'h1FF7F, 32'h00205);
    txt(2);
    // Bad signature, bad check, misplaced null; only signature unmasked
    apb(1'b1, MASK_OFFSET, 32'h2);
    for (int t = 0; t < 3; t++) begin
      all = '{7'h48, (t == 2) ? CHAR_NUL : 7'h69, CHAR_ETX, CHAR_NUL,
        CHAR_NUL};
      sig = sigf(all) + ((t == 0) ? 7'h01 : 7'h00);
      fc = all;
      frag(1'b0, FRAG_START, 1'b0, 6'h06, SPLIT_NONE, t == 1);
      idle();
      chk(irq, {31'h0, t == 0});
      stat(6'h3E, (t == 0) ? 6'h02 : (t == 1) ? 6'h04 : 6'h08);
    end
    // Two fragments, every split pair code, exact fit without end mark
    for (int p = 0; p < 4; p++) begin
      all = '{7'h41, 7'h42, 7'h43, 7'h44, 7'h45};
      sig = sigf(all);
      fc = all[0:1];
      frag(1'b0, FRAG_START, 1'b1, 6'(p), SPLIT_NONE, 1'b0);
      idle();
      stat(6'h3F, 6'h00);
      i_page_encoder_model.gap = 20;
      fc = all[2:4];
      frag(1'b0, 2'h0, 1'b0, 6'(p), 2'(p), 1'b0);
      i_page_encoder_model.gap = 0;
      idle();
      stat(6'h3E, {p == 1, 5'h00});
      apb(1'b0, INFO_OFFSET, 32'h0);
      chk(rd[7:0], {p == 0, p == 3, 6'(p)});
      txt(5);
    end
    // Secure message in order, then with a skipped fragment number
    for (int t = 0; t < 2; t++) begin
      all = '{7'h61, 7'h62, 7'h63, 7'h64, 7'h65, 7'h66};
      fc = all[0:2];
      frag(1'b1, FRAG_START, 1'b1, 6'h09, SPLIT_NONE, 1'b0);
      fc = all[3:5];
      frag(1'b1, 2'(t), 1'b0, 6'h09, SPLIT_NONE, 1'b0);
      idle();
      stat(t ? 6'h3E : 6'h3F, t ? 6'h10 : 6'h01);
      if (t == 0) txt(6);
    end
    // Disabled decoder refuses words
    apb(1'b1, CTRL_OFFSET, 32'h0);
    @(posedge pclk);
    chk(word_ready, 32'h0);
    // Reset in mid-run restores the mask and the enable
    apb(1'b1, MASK_OFFSET, 32'h3F);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, MASK_OFFSET, 32'h0);
    chk(rd, 32'h0);
    chk(word_ready, 32'h1);
    report_and_stop();
  end
endmodule : alpha_decoder_tb_top
